// ==== xhc_tail_top.sv ====
// capability list tail registers and memory window router of the host controller
//
// Notes on behaviour
// R1 - next-capability pointer, upper twelve header bits, always reads zero
// R2 - low four header bits report capability version one
// R3 - header word at 152h, read-only, 0001h after reset, writes ignored
// R4 - 64-bit serial number: 24-bit organisation id plus 40-bit extension
// R5 - serial bits 63:40 hold a wired organisation id, untouched by reset
// R6 - serial bits 39:32 always read zero
// R7 - serial bits 31:0 hold the unique per-part word
// R8 - serial number decoded from 154h, read-only, writes have no effect
// R9 - memory window follows the programmed 64-bit base; software sets it first
// R10 - offsets 000h-01Fh capability, 020h-49Fh operational
// R11 - 4A0h-5BFh runtime, 5C0h-6C3h doorbell, 6C4h-9BFh reserved
// R12 - 9C0h-9EBh extended capabilities, 9ECh-FFFFh reserved
// R13 - offsets counted from the base address, zero at the base
// R14 - reserved reads complete with zeros, reserved writes dropped
`timescale 1ns/1ps
module xhc_tail_top (
	// clock, reset, enable
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// per-part identity word
	input wire logic [31:0] uniqueIdIn,
	// configuration request and completion
	input xhc_tail_pkg::cfg_req_t cfgReq,
	output logic cfgCplValid,
	output logic [31:0] cfgCplData,
	// programmed base address pair
	input wire logic [63:0] barBase,
	input wire logic barProgrammed,
	// memory request, routed request, reserved completion
	input xhc_tail_pkg::mem_req_t memReq,
	output xhc_tail_pkg::route_t routeOut,
	output logic memCplValid,
	output logic [31:0] memCplData,
	output logic [7:0] memCplTag
);

	// ----------------------------------------
	// internal signals
	// ----------------------------------------
	logic [31:0] capRdData;
	logic idCaptured;
	logic winHit;
	logic [15:0] winOffset;
	xhc_tail_pkg::region_t winRegion;
	logic memTake;
	logic cfgCplValid_r;
	logic [31:0] cfgCplData_r;
	xhc_tail_pkg::route_t route_r;
	xhc_tail_pkg::route_t route_nxt;
	logic memCplValid_r;
	logic [31:0] memCplData_r;
	logic [7:0] memCplTag_r;

	// ----------------------------------------
	// sub-blocks
	// ----------------------------------------
	// R4 serial composition
	serial_cap_regs u_caps (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.uniqueIdIn(uniqueIdIn),
		.rdAddr(cfgReq.addr),
		.rdData(capRdData),
		.captured(idCaptured)
	);

	// R13 base relative offset
	mmio_region_decode u_dec (
		.addr(memReq.addr),
		.base(barBase),
		.hit(winHit),
		.offset(winOffset),
		.region(winRegion)
	);

	// ----------------------------------------
	// configuration completions
	// ----------------------------------------
	// R3 writes only complete; there is no storage, so the header cannot change
	// R8 serial read path
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfgCplValid_r <= 1'b0;
			cfgCplData_r <= xhc_tail_pkg::READ_ZERO;
		end else if (ce) begin
			cfgCplValid_r <= cfgReq.valid;
			if (cfgReq.valid)
				cfgCplData_r <= cfgReq.write ? xhc_tail_pkg::READ_ZERO : capRdData;
		end
	end

	// ----------------------------------------
	// memory window routing
	// ----------------------------------------
	// R9 nothing is claimed until software has set the base
	assign memTake = memReq.valid && barProgrammed && winHit;

	// next routed request; reserved space is not forwarded
	always_comb begin
		route_nxt = route_r;
		route_nxt.valid = 1'b0;
		if (memTake) begin
			// R10 R11 R12 region select
			route_nxt.valid = (winRegion != xhc_tail_pkg::REG_RSVD);
			route_nxt.region = winRegion;
			route_nxt.offset = winOffset;
			route_nxt.write = memReq.write;
			route_nxt.byteEn = memReq.byteEn;
			route_nxt.wdata = memReq.wdata;
			route_nxt.tag = memReq.tag;
		end
	end

	// routed request register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			route_r <= '{valid: 1'b0, region: xhc_tail_pkg::REG_RSVD, offset: 16'h0000,
				write: 1'b0, byteEn: 4'h0, wdata: 32'h0000_0000, tag: 8'h00};
		end else if (ce) begin
			route_r <= route_nxt;
		end
	end

	// R14 reserved reads answered here with zeros; reserved writes vanish
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			memCplValid_r <= 1'b0;
			memCplData_r <= xhc_tail_pkg::READ_ZERO;
			memCplTag_r <= 8'h00;
		end else if (ce) begin
			memCplValid_r <= memTake && !memReq.write && (winRegion == xhc_tail_pkg::REG_RSVD);
			memCplData_r <= xhc_tail_pkg::READ_ZERO;
			if (memTake)
				memCplTag_r <= memReq.tag;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign cfgCplValid = cfgCplValid_r;
	assign cfgCplData = cfgCplData_r;
	assign routeOut = route_r;
	assign memCplValid = memCplValid_r;
	assign memCplData = memCplData_r;
	assign memCplTag = memCplTag_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// R1 next pointer zero
	a_next_ptr_zero: assert property (@(posedge clk) disable iff (!resetn) // R1
		(ce && cfgReq.valid && !cfgReq.write && xhc_tail_pkg::dwMatch(cfgReq.addr, xhc_tail_pkg::CFG_HDR_DW_OFS))
		|=> cfgCplValid && cfgCplData[31:20] == xhc_tail_pkg::CAP_NEXT_PTR)
		else $error("next capability pointer not zero");

	// R2 version one
	a_cap_version_one: assert property (@(posedge clk) disable iff (!resetn) // R2
		(ce && cfgReq.valid && !cfgReq.write && xhc_tail_pkg::dwMatch(cfgReq.addr, xhc_tail_pkg::CFG_HDR_DW_OFS))
		|=> cfgCplData[19:16] == xhc_tail_pkg::CAP_VERSION)
		else $error("capability version not one");

	// R3 header survives writes
	a_hdr_write_ignored: assert property (@(posedge clk) disable iff (!resetn) // R3
		(ce && cfgReq.valid && cfgReq.write && xhc_tail_pkg::dwMatch(cfgReq.addr, xhc_tail_pkg::CFG_HDR_DW_OFS))
		##1 (ce && cfgReq.valid && !cfgReq.write
		&& xhc_tail_pkg::dwMatch(cfgReq.addr, xhc_tail_pkg::CFG_HDR_DW_OFS))
		|=> cfgCplData[31:16] == xhc_tail_pkg::CAP_HDR_RESET)
		else $error("header word changed by a write");

	// R5 R6 upper serial word
	a_serial_upper: assert property (@(posedge clk) disable iff (!resetn) // R5
		(ce && cfgReq.valid && !cfgReq.write && xhc_tail_pkg::dwMatch(cfgReq.addr, xhc_tail_pkg::CFG_SERIAL_HI_OFS))
		|=> cfgCplData[31:8] == xhc_tail_pkg::DEFAULT_ORG_ID
		&& cfgCplData[7:0] == xhc_tail_pkg::SERIAL_ZERO_BYTE)
		else $error("serial upper word wrong");

	// R6 zero byte
	a_serial_zero_byte: assert property (@(posedge clk) disable iff (!resetn) // R6
		(ce && cfgReq.valid && !cfgReq.write && xhc_tail_pkg::dwMatch(cfgReq.addr, xhc_tail_pkg::CFG_SERIAL_HI_OFS))
		|=> cfgCplData[7:0] == xhc_tail_pkg::SERIAL_ZERO_BYTE)
		else $error("serial zero byte not zero");

	// R7 R8 lower serial word equals the captured part word
	a_serial_lower: assert property (@(posedge clk) disable iff (!resetn) // R7
		(ce && idCaptured && cfgReq.valid && !cfgReq.write
		&& xhc_tail_pkg::dwMatch(cfgReq.addr, xhc_tail_pkg::CFG_SERIAL_LO_OFS))
		|=> cfgCplData == u_caps.uniqueWord_r)
		else $error("serial lower word wrong");

	// R7 part word frozen once caught
	a_unique_stable: assert property (@(posedge clk) disable iff (!resetn) // R7
		idCaptured |=> $stable(u_caps.uniqueWord_r))
		else $error("unique word changed after capture");

	// R9 no claim without a programmed base
	a_no_claim_unset: assert property (@(posedge clk) disable iff (!resetn) // R9
		(ce && !barProgrammed) |=> !routeOut.valid && !memCplValid)
		else $error("request claimed before base set");

	// R10 R11 R12 routed region matches the decode of the offset
	a_route_region: assert property (@(posedge clk) disable iff (!resetn) // R10
		routeOut.valid |-> routeOut.region != xhc_tail_pkg::REG_RSVD
		&& ((routeOut.region == xhc_tail_pkg::REG_CAP) == (routeOut.offset <= xhc_tail_pkg::CAP_LAST))
		&& ((routeOut.region == xhc_tail_pkg::REG_OP) == (routeOut.offset > xhc_tail_pkg::CAP_LAST
		&& routeOut.offset <= xhc_tail_pkg::OP_LAST))
		&& ((routeOut.region == xhc_tail_pkg::REG_RT) == (routeOut.offset > xhc_tail_pkg::OP_LAST
		&& routeOut.offset <= xhc_tail_pkg::RT_LAST))
		&& ((routeOut.region == xhc_tail_pkg::REG_DB) == (routeOut.offset > xhc_tail_pkg::RT_LAST
		&& routeOut.offset <= xhc_tail_pkg::DB_LAST))
		&& ((routeOut.region == xhc_tail_pkg::REG_EXT) == (routeOut.offset > xhc_tail_pkg::RSVD_LOW_LAST
		&& routeOut.offset <= xhc_tail_pkg::EXT_LAST)))
		else $error("routed region does not match offset");

	// R11 doorbell boundary
	a_route_doorbell: assert property (@(posedge clk) disable iff (!resetn) // R11
		(ce && memTake && winOffset == xhc_tail_pkg::DB_LAST)
		|=> routeOut.valid && routeOut.region == xhc_tail_pkg::REG_DB)
		else $error("last doorbell offset misrouted");

	// R12 extended capability boundary
	a_route_ext_edge: assert property (@(posedge clk) disable iff (!resetn) // R12
		(ce && memTake && winOffset == xhc_tail_pkg::EXT_LAST + 16'h0001)
		|=> !routeOut.valid)
		else $error("offset past extended capabilities routed");

	// R13 offset measured from base
	a_offset_base: assert property (@(posedge clk) disable iff (!resetn) // R13
		(ce && memTake) |=> routeOut.offset == $past(memReq.addr[15:0]) - $past(barBase[15:0])
		&& routeOut.tag == $past(memReq.tag))
		else $error("offset not relative to base");

	// R14 reserved read answers zero
	a_rsvd_read_zero: assert property (@(posedge clk) disable iff (!resetn) // R14
		(ce && memTake && !memReq.write && winRegion == xhc_tail_pkg::REG_RSVD)
		|=> memCplValid && memCplData == xhc_tail_pkg::READ_ZERO && !routeOut.valid)
		else $error("reserved read not answered with zero");

	// R14 reserved write dropped
	a_rsvd_write_drop: assert property (@(posedge clk) disable iff (!resetn) // R14
		(ce && memTake && memReq.write && winRegion == xhc_tail_pkg::REG_RSVD)
		|=> !memCplValid && !routeOut.valid)
		else $error("reserved write had an effect");

	// R3 config writes complete with zero data
	a_cfg_write_zero: assert property (@(posedge clk) disable iff (!resetn) // R3
		(ce && cfgReq.valid && cfgReq.write)
		|=> cfgCplValid && cfgCplData == xhc_tail_pkg::READ_ZERO)
		else $error("config write completion carries data");

	// R8 no completion without a taken request
	a_cfg_no_spurious: assert property (@(posedge clk) disable iff (!resetn) // R8
		(ce && !cfgReq.valid) |=> !cfgCplValid)
		else $error("config completion without a request");

	// R10 last capability offset
	a_route_cap_edge: assert property (@(posedge clk) disable iff (!resetn) // R10
		(ce && memTake && winOffset == xhc_tail_pkg::CAP_LAST)
		|=> routeOut.valid && routeOut.region == xhc_tail_pkg::REG_CAP)
		else $error("last capability offset misrouted");

	// R10 last operational offset
	a_route_op_edge: assert property (@(posedge clk) disable iff (!resetn) // R10
		(ce && memTake && winOffset == xhc_tail_pkg::OP_LAST)
		|=> routeOut.valid && routeOut.region == xhc_tail_pkg::REG_OP)
		else $error("last operational offset misrouted");

	// R11 first runtime offset
	a_route_rt_first: assert property (@(posedge clk) disable iff (!resetn) // R11
		(ce && memTake && winOffset == xhc_tail_pkg::OP_LAST + 16'h0001)
		|=> routeOut.valid && routeOut.region == xhc_tail_pkg::REG_RT)
		else $error("first runtime offset misrouted");

	// R11 reserved gap after the doorbells
	a_rsvd_gap_start: assert property (@(posedge clk) disable iff (!resetn) // R11
		(ce && memTake && winOffset == xhc_tail_pkg::DB_LAST + 16'h0001)
		|=> !routeOut.valid)
		else $error("offset past the doorbells routed");

	// R12 first extended capability offset
	a_route_ext_first: assert property (@(posedge clk) disable iff (!resetn) // R12
		(ce && memTake && winOffset == xhc_tail_pkg::RSVD_LOW_LAST + 16'h0001)
		|=> routeOut.valid && routeOut.region == xhc_tail_pkg::REG_EXT)
		else $error("first extended capability offset misrouted");

	// R13 misses leave no trace
	a_miss_silent: assert property (@(posedge clk) disable iff (!resetn) // R13
		(ce && memReq.valid && !winHit)
		|=> !routeOut.valid && !memCplValid)
		else $error("request outside the window claimed");

	// R13 the base itself is offset zero
	a_base_offset_zero: assert property (@(posedge clk) disable iff (!resetn) // R13
		(ce && memTake && memReq.addr == barBase)
		|=> routeOut.offset == 16'h0000 && routeOut.region == xhc_tail_pkg::REG_CAP)
		else $error("base address not at offset zero");

	// clock enable low freezes every output; memCplData holds too but is not compared
	a_ce_freeze: assert property (@(posedge clk) disable iff (!resetn) // R3
		!ce |=> $stable(cfgCplValid) && $stable(cfgCplData) && $stable(routeOut)
		&& $stable(memCplValid) && $stable(memCplTag))
		else $error("outputs moved while clock enable low");

endmodule : xhc_tail_top

// ==== xhc_tail_pkg.sv ====
// shared constants and carrier types for the capability tail and memory window decoder
package xhc_tail_pkg;

	// ----------------------------------------
	// extended configuration offsets
	// ----------------------------------------
	localparam logic [11:0] CFG_HDR_DW_OFS = 12'h0150;
	localparam logic [11:0] CFG_CAP_HDR_OFS = 12'h0152;
	localparam logic [11:0] CFG_SERIAL_LO_OFS = 12'h0154;
	localparam logic [11:0] CFG_SERIAL_HI_OFS = 12'h0158;
	localparam int HDR_HALF_LSB = 16;
	localparam int DW_INDEX_LSB = 2;

	// ----------------------------------------
	// capability header word layout
	// ----------------------------------------
	localparam logic [15:0] CAP_HDR_RESET = 16'h0001;
	localparam logic [11:0] CAP_NEXT_PTR = 12'h0000;
	localparam logic [3:0] CAP_VERSION = 4'h1;
	localparam int HDR_VER_LSB = 0;
	localparam int HDR_NEXT_LSB = 4;

	// ----------------------------------------
	// serial number layout
	// ----------------------------------------
	localparam logic [23:0] DEFAULT_ORG_ID = 24'hA5_5A3C; // arbitrary value
	localparam logic [7:0] SERIAL_ZERO_BYTE = 8'h00;
	localparam int SERIAL_ORG_LSB = 40;
	localparam int SERIAL_ZERO_LSB = 32;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// ----------------------------------------
	// memory window region bounds
	// ----------------------------------------
	localparam int WINDOW_BITS = 16;
	localparam logic [15:0] CAP_LAST = 16'h001F;
	localparam logic [15:0] OP_LAST = 16'h049F;
	localparam logic [15:0] RT_LAST = 16'h05BF;
	localparam logic [15:0] DB_LAST = 16'h06C3;
	localparam logic [15:0] RSVD_LOW_LAST = 16'h09BF;
	localparam logic [15:0] EXT_LAST = 16'h09EB;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [5:0] {
		REG_CAP = 6'b00_0001,
		REG_OP = 6'b00_0010,
		REG_RT = 6'b00_0100,
		REG_DB = 6'b00_1000,
		REG_EXT = 6'b01_0000,
		REG_RSVD = 6'b10_0000
	} region_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} cfg_req_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [63:0] addr;
		logic [3:0] byteEn;
		logic [31:0] wdata;
		logic [7:0] tag;
	} mem_req_t;

	typedef struct packed {
		logic valid;
		region_t region;
		logic [15:0] offset;
		logic write;
		logic [3:0] byteEn;
		logic [31:0] wdata;
		logic [7:0] tag;
	} route_t;

	// region lookup for a window offset, used by the decoder; the checks compare the bounds directly
	function automatic region_t decodeRegion(input logic [15:0] ofs);
		region_t r;
		r = REG_RSVD;
		if (ofs <= CAP_LAST) r = REG_CAP;
		else if (ofs <= OP_LAST) r = REG_OP;
		else if (ofs <= RT_LAST) r = REG_RT;
		else if (ofs <= DB_LAST) r = REG_DB;
		else if (ofs <= RSVD_LOW_LAST) r = REG_RSVD;
		else if (ofs <= EXT_LAST) r = REG_EXT;
		return r;
	endfunction : decodeRegion

	// dword match of a configuration byte address
	function automatic logic dwMatch(input logic [11:0] addr, input logic [11:0] ofs);
		return addr[11:DW_INDEX_LSB] == ofs[11:DW_INDEX_LSB];
	endfunction : dwMatch

endpackage : xhc_tail_pkg

// ==== serial_cap_regs.sv ====
// read-only capability header and serial number words
`timescale 1ns/1ps
module serial_cap_regs #(
	parameter logic [23:0] ORG_ID = xhc_tail_pkg::DEFAULT_ORG_ID // arbitrary value
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// per-part identity word
	input wire logic [31:0] uniqueIdIn,
	// read port
	input wire logic [11:0] rdAddr,
	output logic [31:0] rdData,
	output logic captured
);

	logic [31:0] uniqueWord_r;
	logic captured_r;
	logic [15:0] hdrWord;
	logic [63:0] serial;

	// R7 catch part word
	// taken once after reset release; a pin cannot feed an async reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			uniqueWord_r <= xhc_tail_pkg::READ_ZERO;
			captured_r <= 1'b0;
		end else if (ce && !captured_r) begin
			uniqueWord_r <= uniqueIdIn;
			captured_r <= 1'b1;
		end
	end

	// R1 R2 wired header word
	assign hdrWord = {xhc_tail_pkg::CAP_NEXT_PTR, xhc_tail_pkg::CAP_VERSION};
	// R5 R6 wired upper serial; only the unique word is stored
	assign serial = {ORG_ID, xhc_tail_pkg::SERIAL_ZERO_BYTE, uniqueWord_r};
	assign captured = captured_r;

	// dword read mux; unknown dwords read zero
	always_comb begin
		rdData = xhc_tail_pkg::READ_ZERO;
		if (xhc_tail_pkg::dwMatch(rdAddr, xhc_tail_pkg::CFG_CAP_HDR_OFS))
			rdData = {hdrWord, 16'h0000};
		else if (xhc_tail_pkg::dwMatch(rdAddr, xhc_tail_pkg::CFG_SERIAL_LO_OFS))
			rdData = serial[31:0];
		else if (xhc_tail_pkg::dwMatch(rdAddr, xhc_tail_pkg::CFG_SERIAL_HI_OFS))
			rdData = serial[63:32];
	end

endmodule : serial_cap_regs

// ==== mmio_region_decode.sv ====
// base-relative memory window hit and region decode
`timescale 1ns/1ps
module mmio_region_decode (
	// request address and programmed base
	input wire logic [63:0] addr,
	input wire logic [63:0] base,
	// decode result
	output logic hit,
	output logic [15:0] offset,
	output xhc_tail_pkg::region_t region
);

	logic [64:0] diff;

	// offset measured from the base so offset zero sits at the base itself
	assign diff = {1'b0, addr} - {1'b0, base};
	assign hit = (diff[64:xhc_tail_pkg::WINDOW_BITS] == '0);
	assign offset = diff[15:0];
	assign region = xhc_tail_pkg::decodeRegion(diff[15:0]);

endmodule : mmio_region_decode

// ==== host_rc_model.sv ====
// host side model that issues configuration and memory requests toward the device
`timescale 1ns/1ps
module host_rc_model (
	// clock
	input wire logic clk,
	// requests toward the device
	output xhc_tail_pkg::cfg_req_t cfgReq,
	output xhc_tail_pkg::mem_req_t memReq,
	// base address pair
	output logic [63:0] barBase,
	output logic barProgrammed
);
	// ----------------------------------------
	// idle state
	// ----------------------------------------
	// bus idle with no base programmed
	initial begin
		cfgReq = '0;
		memReq = '0;
		barBase = 64'h0000_0000_0000_0000;
		barProgrammed = 1'b0;
	end

	// ----------------------------------------
	// request tasks
	// ----------------------------------------
	// base programmed before access
	task automatic programBase(input logic [63:0] base);
		@(posedge clk);
		#1;
		barBase = base;
		barProgrammed = 1'b1;
	endtask : programBase

	// one config request, idle cycles first so both fast and slow hosts are seen
	task automatic cfgIssue(input logic wr, input logic [11:0] addr, input logic [31:0] data, input int idle);
		repeat (idle) @(posedge clk);
		@(posedge clk);
		#1;
		cfgReq.valid = 1'b1;
		cfgReq.write = wr;
		cfgReq.addr = addr;
		cfgReq.wdata = data;
		@(posedge clk);
		#1;
		cfgReq.valid = 1'b0;
		// a released bus must not keep showing the last value
		cfgReq.addr = ~addr;
		cfgReq.wdata = ~data;
	endtask : cfgIssue

	// two config requests on consecutive edges; valid stays high between them
	task automatic cfgPair(input logic wr0, input logic [11:0] addr0, input logic wr1, input logic [11:0] addr1);
		@(posedge clk);
		#1;
		cfgReq.valid = 1'b1;
		cfgReq.write = wr0;
		cfgReq.addr = addr0;
		cfgReq.wdata = 32'hFFFF_FFFF;
		@(posedge clk);
		#1;
		cfgReq.write = wr1;
		cfgReq.addr = addr1;
		@(posedge clk);
		#1;
		cfgReq.valid = 1'b0;
		cfgReq.addr = ~addr1;
		cfgReq.wdata = 32'h0000_0000;
	endtask : cfgPair

	// one memory request of a full dword
	task automatic memIssue(input logic wr, input logic [63:0] addr, input logic [7:0] tag, input int idle);
		repeat (idle) @(posedge clk);
		@(posedge clk);
		#1;
		memReq.valid = 1'b1;
		memReq.write = wr;
		memReq.addr = addr;
		memReq.byteEn = 4'hF;
		memReq.wdata = 32'hC3C3_5A5A;
		memReq.tag = tag;
		@(posedge clk);
		#1;
		memReq.valid = 1'b0;
		memReq.addr = ~addr;
		memReq.wdata = 32'h3C3C_A5A5;
		memReq.tag = ~tag;
	endtask : memIssue

endmodule : host_rc_model

// ==== xhc_tail_top_tb.sv ====
// self-checking testbench for the capability tail and memory window router
`timescale 1ns/1ps
module xhc_tail_top_tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam logic [31:0] UNIQUE_WORD = 32'h1357_9BDF;
	localparam logic [63:0] BASE = 64'h0000_0001_F00D_0000;
	logic clk;
	logic resetn;
	logic ce;
	logic [31:0] uniqueIdIn;
	xhc_tail_pkg::cfg_req_t cfgReq;
	xhc_tail_pkg::mem_req_t memReq;
	logic [63:0] barBase;
	logic barProgrammed;
	logic cfgCplValid;
	logic [31:0] cfgCplData;
	xhc_tail_pkg::route_t routeOut;
	logic memCplValid;
	logic [31:0] memCplData;
	logic [7:0] memCplTag;
	int fails = 0;
	int samples_checked = 0;
	logic [15:0] ofsTab [14] = '{16'h0000, 16'h001F, 16'h0020, 16'h049F, 16'h04A0, 16'h05BF, 16'h05C0,
		16'h06C3, 16'h06C4, 16'h09BF, 16'h09C0, 16'h09EB, 16'h09EC, 16'hFFFC};
	logic [5:0] regTab [14] = '{6'h01, 6'h01, 6'h02, 6'h02, 6'h04, 6'h04, 6'h08, 6'h08, 6'h20, 6'h20,
		6'h10, 6'h10, 6'h20, 6'h20};
	logic [11:0] cfgAddr [3] = '{12'h150, 12'h154, 12'h158};
	logic [31:0] cfgExp [3];

	// clock and fixed inputs
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	initial begin
		ce = 1'b1;
		uniqueIdIn = UNIQUE_WORD;
		resetn = 1'b0;
	end

	// ----------------------------------------
	// design and host
	// ----------------------------------------
	xhc_tail_top DUT (.clk(clk), .resetn(resetn), .ce(ce), .uniqueIdIn(uniqueIdIn), .cfgReq(cfgReq),
		.cfgCplValid(cfgCplValid), .cfgCplData(cfgCplData), .barBase(barBase), .barProgrammed(barProgrammed),
		.memReq(memReq), .routeOut(routeOut), .memCplValid(memCplValid), .memCplData(memCplData),
		.memCplTag(memCplTag));
	host_rc_model host (.clk(clk), .cfgReq(cfgReq), .memReq(memReq), .barBase(barBase),
		.barProgrammed(barProgrammed));

	// ----------------------------------------
	// compare and access tasks
	// ----------------------------------------
	task automatic chkWord(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chkWord

	task automatic chkFlag(input string name, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %b seen %b", name, exp, got);
		end
	endtask : chkFlag

	// config access: one-cycle completion, then the pulse must drop
	task automatic cfgCheck(input logic wr, input logic [11:0] addr, input logic [31:0] exp, input int idle);
		host.cfgIssue(wr, addr, 32'hFFFF_FFFF, idle);
		chkFlag("cfg completion", 1'b1, cfgCplValid);
		chkWord("cfg data", exp, cfgCplData);
		@(posedge clk);
		#1;
		chkFlag("cfg pulse end", 1'b0, cfgCplValid);
	endtask : cfgCheck

	// memory access: routed pulse or reserved completion, or nothing
	task automatic memCheck(input logic wr, input logic [63:0] addr, input logic [5:0] expReg, input logic hit);
		logic isRsvd;
		isRsvd = (expReg == 6'h20);
		host.memIssue(wr, addr, {2'b00, addr[7:2]}, 0);
		chkFlag("route valid", hit & !isRsvd, routeOut.valid);
		chkFlag("reserved completion", hit & isRsvd & !wr, memCplValid);
		if (hit && !isRsvd) begin
			chkWord("route region", {26'h000_0000, expReg}, {26'h000_0000, routeOut.region});
			chkWord("route offset", {16'h0000, addr[15:0]}, {16'h0000, routeOut.offset});
			chkWord("route tag", {24'h00_0000, 2'b00, addr[7:2]}, {24'h00_0000, routeOut.tag});
			chkWord("route data", 32'hC3C3_5A5A, routeOut.wdata);
			chkFlag("route write", wr, routeOut.write);
			chkFlag("route byte enables", 1'b1, &routeOut.byteEn);
		end
		if (hit && isRsvd && !wr) begin
			chkWord("reserved data", 32'h0000_0000, memCplData);
			chkWord("completion tag", {24'h00_0000, 2'b00, addr[7:2]}, {24'h00_0000, memCplTag});
		end
		@(posedge clk);
		#1;
		chkFlag("mem pulse end", 1'b0, routeOut.valid | memCplValid);
	endtask : memCheck

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report

	// ----------------------------------------
	// tests
	// ----------------------------------------
	// watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge clk);
		fails++;
		$display("MISMATCH watchdog expected finish seen hang");
		final_report();
	end

	initial begin
		cfgExp = '{32'h0001_0000, UNIQUE_WORD, {xhc_tail_pkg::DEFAULT_ORG_ID, 8'h00}};
		repeat (20) @(posedge clk);
		#1;
		resetn = 1'b1;
		repeat (2) @(posedge clk);
		// read, write with all ones, read again: words never change
		for (int i = 0; i < 3; i++) begin
			cfgCheck(1'b0, cfgAddr[i], cfgExp[i], i);
			cfgCheck(1'b1, cfgAddr[i], 32'h0000_0000, 0);
			cfgCheck(1'b0, cfgAddr[i], cfgExp[i], 0);
		end
		// header byte address, an unknown dword, then back-to-back write and read
		cfgCheck(1'b0, 12'h152, 32'h0001_0000, 0);
		cfgCheck(1'b0, 12'h15C, 32'h0000_0000, 0);
		host.cfgPair(1'b1, 12'h152, 1'b0, 12'h150);
		chkFlag("pair completion", 1'b1, cfgCplValid);
		chkWord("pair header", 32'h0001_0000, cfgCplData);
		host.cfgPair(1'b1, 12'h154, 1'b0, 12'h154);
		chkWord("pair serial", UNIQUE_WORD, cfgCplData);
		// clock enable low: a request is not taken and outputs hold
		@(posedge clk);
		#1;
		ce = 1'b0;
		host.cfgIssue(1'b0, 12'h158, 32'hFFFF_FFFF, 0);
		chkFlag("frozen cfg completion", 1'b0, cfgCplValid);
		chkWord("frozen cfg data", UNIQUE_WORD, cfgCplData);
		@(posedge clk);
		#1;
		ce = 1'b1;
		// no decode before the base pair is programmed
		memCheck(1'b1, 64'h0000_0000_0000_05C0, 6'h08, 1'b0);
		host.programBase(BASE);
		for (int i = 0; i < 14; i++) begin
			memCheck(1'b1, BASE + {48'h0000_0000_0000, ofsTab[i]}, regTab[i], 1'b1);
			memCheck(1'b0, BASE + {48'h0000_0000_0000, ofsTab[i]}, regTab[i], 1'b1);
		end
		// just outside the window on both sides
		memCheck(1'b0, BASE + 64'h0000_0000_0001_0000, 6'h20, 1'b0);
		memCheck(1'b1, BASE - 64'h0000_0000_0000_0004, 6'h01, 1'b0);
		// a pin change after capture is not seen until the next reset
		uniqueIdIn = ~UNIQUE_WORD;
		cfgCheck(1'b0, 12'h154, UNIQUE_WORD, 0);
		// second reset in mid-run: outputs clear, header intact, part word caught again
		@(posedge clk);
		#1;
		resetn = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chkWord("reset cfg data", 32'h0000_0000, cfgCplData);
		chkFlag("reset outputs", 1'b0, cfgCplValid | routeOut.valid | memCplValid);
		resetn = 1'b1;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			#1;
			chkFlag("idle after reset", 1'b0, cfgCplValid | routeOut.valid | memCplValid);
		end
		cfgCheck(1'b0, 12'h150, 32'h0001_0000, 0);
		cfgCheck(1'b0, 12'h154, ~UNIQUE_WORD, 0);
		final_report();
	end

endmodule : xhc_tail_top_tb
